// [core/encoder_feedback_interface.sv]
// Motor encoder feedback block: quadrature and serial absolute encoder with AXI4-Lite registers
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`include "encoder_feedback_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module encoder_feedback_interface (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic phase_a_or_serial_data_in,
	input wire logic phase_b_in,
	input wire logic index_or_serial_clock_in,
	output logic index_or_serial_clock_out,
	output logic index_or_serial_clock_oe_n,
	output logic [31:0] position_out,
	output logic position_strobe,
	output logic position_primary,
	output logic irq
);
	encoder_feedback_pkg::feedback_state_type s_q;
	encoder_feedback_pkg::feedback_state_type s_d;
	encoder_feedback_pkg::quad_pins_type pins;
	encoder_feedback_pkg::link_mode_type mode;
	logic [2:0] pins_sync;
	logic [31:0] quad_count;
	logic quad_index;
	logic quad_error;
	logic serial;
	logic biss;
	logic din;
	logic fall;
	logic samp;
	logic start_cmd;
	logic reduced;
	logic [6:0] events;
	logic [6:0] w1c;
	logic [6:0] len;
	logic [6:0] last_bit;
	logic [7:0] div;
	logic [15:0] half3;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return r;
	endfunction : wr_merge

	function automatic logic [5:0] crc6_step(input logic [5:0] crc, input logic bit_in);
		logic fb;
		fb = crc[5] ^ bit_in;
		return {crc[4:0], 1'b0} ^ (fb ? `CRC_POLY : 6'h00);
	endfunction : crc6_step

	function automatic logic [7:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] d;
		d = (a > b) ? a - b : 16'h0000;
		return (d > 16'h00ff) ? 8'hff : d[7:0];
	endfunction : sat_sub

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and quadrature decoder
	input_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pins_in({phase_a_or_serial_data_in, phase_b_in, index_or_serial_clock_in}),
		.pins_out(pins_sync)
	);

	assign pins = encoder_feedback_pkg::quad_pins_type'(pins_sync);
	assign mode = encoder_feedback_pkg::link_mode_type'(s_q.ctrl[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
	assign serial = mode != encoder_feedback_pkg::MODE_INCR;
	assign biss = s_q.ctrl[`CTRL_MODE_MSB];
	assign din = pins.a;
	assign len = {1'b0, s_q.cfg[`CFG_LEN_MSB:`CFG_LEN_LSB]};
	assign div = s_q.cfg[`CFG_DIV_MSB:`CFG_DIV_LSB];
	assign half3 = 16'({8'h00, div} + 16'h0001) * 16'h0003;
	assign last_bit = biss ? 7'(len + `CRC_TAIL) : len;

	quadrature_counter u_quad (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(!serial),
		.pins(pins),
		.count(quad_count),
		.index_pulse(quad_index),
		.step_error(quad_error)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		events = '0;
		w1c = '0;
		start_cmd = 1'b0;
		fall = 1'b0;
		reduced = 1'b0;
		s_d.pos_strobe = 1'b0;
		samp = s_q.pend && (s_q.dly_run == 8'h00);

		// Write channel: address and data taken in either order
		if (awvalid && s_q.awready) begin
			s_d.aw_ok = 1'b1;
			s_d.aw_addr = awaddr[`ADDR_W-1:0];
		end
		if (wvalid && s_q.wready) begin
			s_d.w_ok = 1'b1;
			s_d.w_data = wdata;
			s_d.w_strb = wstrb;
		end
		if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = `RESP_OKAY;
			case (s_q.aw_addr)
				`REG_CTRL: begin
					s_d.ctrl = wr_merge(s_q.ctrl, s_q.w_data, s_q.w_strb); // [RQ3]
					s_d.ctrl[`CTRL_START] = 1'b0;
					start_cmd = s_q.w_strb[0] & s_q.w_data[`CTRL_START];
				end
				`REG_CFG: begin
					s_d.cfg = wr_merge(s_q.cfg, s_q.w_data, s_q.w_strb); // [RQ5]
				end
				`REG_CPR: begin
					s_d.cpr = wr_merge(s_q.cpr, s_q.w_data, s_q.w_strb); // [RQ5]
				end
				`REG_STATUS: begin
					w1c = s_q.w_data[`ST_W-1:0] & {`ST_W{s_q.w_strb[0]}};
				end
				`REG_MASK: begin
					s_d.mask = `ST_W'(wr_merge({25'h0, s_q.mask}, s_q.w_data, s_q.w_strb));
				end
				default: begin
					s_d.bresp = `RESP_SLVERR;
				end
			endcase
		end
		if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		s_d.awready = !s_d.aw_ok && !s_d.bvalid;
		s_d.wready = !s_d.w_ok && !s_d.bvalid;

		// Read channel
		if (arvalid && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = `RESP_OKAY;
			case (araddr[`ADDR_W-1:0])
				`REG_CTRL: s_d.rdata = s_q.ctrl;
				`REG_CFG: s_d.rdata = s_q.cfg;
				`REG_CPR: s_d.rdata = s_q.cpr;
				`REG_POSITION: s_d.rdata = s_q.position;
				`REG_TURNS: s_d.rdata = s_q.turns;
				`REG_RAW_LO: s_d.rdata = s_q.raw[31:0];
				`REG_RAW_HI: s_d.rdata = s_q.raw[63:32];
				`REG_STATUS: s_d.rdata = {25'h0, s_q.status};
				`REG_MASK: s_d.rdata = {25'h0, s_q.mask};
				`REG_INDEX_POS: s_d.rdata = s_q.index_pos;
				`REG_LINE_DELAY: s_d.rdata = {24'h0, s_q.line_delay};
				default: begin
					s_d.rdata = 32'h0000_0000;
					s_d.rresp = `RESP_SLVERR;
				end
			endcase
		end
		if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
		s_d.arready = !s_d.rvalid;

		////////////////////////////////////////////////////////////////////////
		// Serial clock generator; idle level is high
		if (s_q.clk_run) begin
			if (s_q.div_cnt == 8'h00) begin
				s_d.sclk = ~s_q.sclk; // [RQ4] [RQ8]
				s_d.div_cnt = div;
				fall = s_q.sclk;
			end else begin
				s_d.div_cnt = s_q.div_cnt - 8'h01;
			end
		end

		// Sample a set delay after each falling edge
		if (fall) begin
			s_d.pend = 1'b1; // [RQ7]
			s_d.dly_run = s_q.line_delay; // [RQ9]
		end else if (samp) begin
			s_d.pend = 1'b0;
		end else if (s_q.pend) begin
			s_d.dly_run = s_q.dly_run - 8'h01;
		end

		case (s_q.state)
			encoder_feedback_pkg::ST_IDLE: begin
				s_d.clk_run = 1'b0;
				s_d.sclk = 1'b1; // [RQ6]
				if (serial && (start_cmd || (s_q.ctrl[`CTRL_RUN] &&
					mode != encoder_feedback_pkg::MODE_BISS_B))) begin // [RQ11]
					s_d.clk_run = 1'b1; // [RQ4]
					s_d.div_cnt = div;
					s_d.bit_cnt = 7'h00;
					s_d.pend = 1'b0;
					s_d.shift = '0;
					s_d.crc_calc = 6'h00;
					s_d.crc_rx = 6'h00;
					s_d.meas_on = 1'b0;
					s_d.meas = 16'h0000;
					if (biss) begin
						s_d.state = encoder_feedback_pkg::ST_ACK;
					end else begin
						s_d.line_delay = `SSI_SAMPLE_DELAY;
						s_d.state = encoder_feedback_pkg::ST_DATA;
					end
				end
			end
			encoder_feedback_pkg::ST_ACK: begin
				// Time from first falling edge to the acknowledge gives the loop delay
				if (fall && !s_q.meas_on) begin
					s_d.meas_on = 1'b1;
				end else if (s_q.meas_on) begin
					s_d.meas = s_q.meas + 16'h0001;
				end
				if (fall) begin
					s_d.bit_cnt = s_q.bit_cnt + 7'h01;
				end
				if (s_q.meas_on && s_q.meas > half3 && !din) begin
					s_d.line_delay = sat_sub(s_q.meas, half3); // [RQ9]
					s_d.bit_cnt = 7'h00;
					s_d.state = encoder_feedback_pkg::ST_START;
				end else if (s_q.bit_cnt == `ACK_LIMIT) begin
					events[`ST_TIMEOUT] = 1'b1;
					s_d.clk_run = 1'b0;
					s_d.sclk = 1'b1;
					s_d.rec_cnt = 16'(`RECOVERY_CYCLES);
					s_d.published = 1'b1;
					s_d.state = encoder_feedback_pkg::ST_RECOVER;
				end
			end
			encoder_feedback_pkg::ST_START: begin
				if (fall) begin
					s_d.bit_cnt = s_q.bit_cnt + 7'h01;
				end
				if (samp && din) begin
					s_d.bit_cnt = 7'h00;
					s_d.state = encoder_feedback_pkg::ST_DATA;
				end else if (s_q.bit_cnt == `ACK_LIMIT) begin
					events[`ST_TIMEOUT] = 1'b1;
					s_d.clk_run = 1'b0;
					s_d.sclk = 1'b1;
					s_d.rec_cnt = 16'(`RECOVERY_CYCLES);
					s_d.published = 1'b1;
					s_d.state = encoder_feedback_pkg::ST_RECOVER;
				end
			end
			encoder_feedback_pkg::ST_DATA: begin
				// Bit 0 is the latch or control bit and is dropped
				if (samp) begin
					s_d.bit_cnt = s_q.bit_cnt + 7'h01;
					if (s_q.bit_cnt != 7'h00 && s_q.bit_cnt <= len) begin
						s_d.shift = {s_q.shift[62:0], din}; // [RQ4] [RQ5]
					end
					if (biss && s_q.bit_cnt != 7'h00 && s_q.bit_cnt <= 7'(len + 7'h02)) begin
						s_d.crc_calc = crc6_step(s_q.crc_calc, din); // [RQ10]
					end
					if (s_q.bit_cnt == 7'(len + 7'h01)) begin
						s_d.err_bit = din;
					end
					if (s_q.bit_cnt == 7'(len + 7'h02)) begin
						s_d.warn_bit = din;
					end
					if (s_q.bit_cnt > 7'(len + 7'h02)) begin
						s_d.crc_rx = {s_q.crc_rx[4:0], din};
					end
					if (s_q.bit_cnt == last_bit) begin
						s_d.clk_run = 1'b0;
						s_d.sclk = 1'b1; // [RQ6]
						s_d.pend = 1'b0;
						s_d.rec_cnt = 16'(`RECOVERY_CYCLES); // [RQ13]
						s_d.published = 1'b0;
						s_d.work = s_d.shift;
						s_d.raw = s_d.shift;
						s_d.turns_work = 32'h0000_0000;
						events[`ST_CRC] = biss && (~s_d.crc_rx != s_d.crc_calc); // [RQ10]
						events[`ST_ENC_ERR] = biss && !s_d.err_bit; // [RQ10]
						events[`ST_ENC_WARN] = biss && !s_d.warn_bit; // [RQ10]
						s_d.state = encoder_feedback_pkg::ST_RECOVER;
					end
				end
			end
			encoder_feedback_pkg::ST_RECOVER: begin
				// Split the word into turns and position within the turn
				reduced = (s_q.cpr == 32'h0000_0000) || (s_q.work < {32'h0, s_q.cpr});
				if (!reduced) begin
					s_d.work = s_q.work - {32'h0, s_q.cpr}; // [RQ5]
					s_d.turns_work = s_q.turns_work + 32'h0000_0001;
				end else if (!s_q.published) begin
					s_d.published = 1'b1;
					s_d.position = s_q.work[31:0];
					s_d.turns = s_q.turns_work;
					s_d.pos_strobe = 1'b1;
					events[`ST_DONE] = 1'b1;
				end
				if (s_q.rec_cnt != 16'h0000) begin
					s_d.rec_cnt = s_q.rec_cnt - 16'h0001;
				end else if (reduced || s_q.published) begin
					s_d.state = encoder_feedback_pkg::ST_IDLE; // [RQ13]
				end
			end
			default: begin
				s_d.state = encoder_feedback_pkg::ST_IDLE;
			end
		endcase

		if (!serial) begin
			s_d.state = encoder_feedback_pkg::ST_IDLE;
			s_d.clk_run = 1'b0;
			s_d.sclk = 1'b1;
			if (s_d.position != quad_count) begin
				s_d.pos_strobe = 1'b1;
			end
			s_d.position = quad_count; // [RQ1]
			if (quad_index) begin
				s_d.index_pos = quad_count; // [RQ2]
			end
			events[`ST_INDEX] = quad_index; // [RQ2]
			events[`ST_QUAD_ERR] = quad_error;
		end

		// Pin drives the clock only in serial modes
		s_d.clk_oe_n = !serial; // [RQ8]
		s_d.pos_primary = !s_d.ctrl[`CTRL_SECONDARY]; // [RQ3]
		// New events win over a clear in the same cycle
		s_d.status = (s_q.status & ~w1c) | events;
		s_d.irq = |(s_d.status & s_d.mask);
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.ctrl <= `CTRL_RESET;
			s_q.cfg <= `CFG_RESET;
			s_q.cpr <= `CPR_RESET;
			s_q.state <= encoder_feedback_pkg::ST_IDLE;
			s_q.sclk <= 1'b1;
			s_q.clk_oe_n <= 1'b1;
			s_q.pos_primary <= 1'b1;
			s_q.published <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign awready = s_q.awready;
	assign wready = s_q.wready;
	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign arready = s_q.arready;
	assign rvalid = s_q.rvalid;
	assign rresp = s_q.rresp;
	assign rdata = s_q.rdata;
	assign index_or_serial_clock_out = s_q.sclk;
	assign index_or_serial_clock_oe_n = s_q.clk_oe_n;
	assign position_out = s_q.position;
	assign position_strobe = s_q.pos_strobe;
	assign position_primary = s_q.pos_primary;
	assign irq = s_q.irq;
endmodule : encoder_feedback_interface
`default_nettype wire

// [core/encoder_feedback_cfg.svh]
// Register map, field positions, reset values and timing counts of the encoder feedback block
// Behaviour
// [RQ1] Incremental mode turns the A and B quadrature channels into the motor position count.
// [RQ2] An optional index channel gives a once-per-turn marker that latches the count.
// [RQ3] A control bit says whether the motor encoder channel feeds primary or secondary feedback.
// [RQ4] Serial mode sends a clock burst and the encoder shifts its bits out on the pulses after it.
// [RQ5] Serial word length and counts per revolution are programmable and shape the position.
// [RQ6] The serial clock rests idle between frames and toggles only during a transfer.
// [RQ7] Each serial data bit is sampled at a falling edge of the clock that the block makes.
// [RQ8] The serial link has one clock line out to the encoder and one data line back.
// [RQ9] The serial mode with acknowledge measures the round-trip line delay and samples that late.
// [RQ10] That mode checks the frame CRC and reports the encoder error and warning bits as status.
// [RQ11] Its B variant starts each cycle on command, its C variant runs frames continuously.
// [RQ12] Four counts per quadrature cycle, up or down by which channel leads.
// [RQ13] After the last bit the clock stays idle for a recovery time before the next frame.
`ifndef ENCODER_FEEDBACK_CFG_SVH
`define ENCODER_FEEDBACK_CFG_SVH

`define ADDR_W 8
`define REG_CTRL 8'h00
`define REG_CFG 8'h04
`define REG_CPR 8'h08
`define REG_POSITION 8'h0c
`define REG_TURNS 8'h10
`define REG_RAW_LO 8'h14
`define REG_RAW_HI 8'h18
`define REG_STATUS 8'h1c
`define REG_MASK 8'h20
`define REG_INDEX_POS 8'h24
`define REG_LINE_DELAY 8'h28

`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_RUN 2
`define CTRL_SECONDARY 3
`define CTRL_START 4
`define CFG_LEN_LSB 0
`define CFG_LEN_MSB 5
`define CFG_DIV_LSB 8
`define CFG_DIV_MSB 15

`define CTRL_RESET 32'h0000_0000
`define CFG_RESET 32'h0000_0419
`define CPR_RESET 32'h0000_0000

`define ST_W 7
`define ST_DONE 0
`define ST_CRC 1
`define ST_ENC_ERR 2
`define ST_ENC_WARN 3
`define ST_TIMEOUT 4
`define ST_INDEX 5
`define ST_QUAD_ERR 6

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CLK_PERIOD_NS 10
`define RECOVERY_NS 20000
`define RECOVERY_CYCLES ((`RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SSI_SAMPLE_DELAY 8'h03
`define ACK_LIMIT 7'h20
`define CRC_POLY 6'h03
`define CRC_TAIL 7'h08

`endif

// [core/encoder_feedback_pkg.sv]
// Types shared by the encoder feedback block
`default_nettype none
package encoder_feedback_pkg;
	typedef enum logic [1:0] {
		MODE_INCR = 2'h0,
		MODE_SSI = 2'h1,
		MODE_BISS_B = 2'h2,
		MODE_BISS_C = 2'h3
	} link_mode_type;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ACK = 5'h02,
		ST_START = 5'h04,
		ST_DATA = 5'h08,
		ST_RECOVER = 5'h10
	} frame_state_type;

	typedef struct packed {
		logic a;
		logic b;
		logic x;
	} quad_pins_type;

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] val;
	} sync_state_type;

	typedef struct packed {
		logic [1:0] prev_ab;
		logic prev_x;
		logic [31:0] count;
		logic index_pulse;
		logic step_error;
	} quad_state_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic aw_ok;
		logic w_ok;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] ctrl;
		logic [31:0] cfg;
		logic [31:0] cpr;
		logic [6:0] status;
		logic [6:0] mask;
		frame_state_type state;
		logic clk_run;
		logic sclk;
		logic clk_oe_n;
		logic [7:0] div_cnt;
		logic [6:0] bit_cnt;
		logic pend;
		logic [7:0] dly_run;
		logic [7:0] line_delay;
		logic meas_on;
		logic [15:0] meas;
		logic [63:0] shift;
		logic [5:0] crc_calc;
		logic [5:0] crc_rx;
		logic err_bit;
		logic warn_bit;
		logic [15:0] rec_cnt;
		logic published;
		logic [63:0] work;
		logic [31:0] turns_work;
		logic [31:0] position;
		logic [31:0] turns;
		logic [63:0] raw;
		logic [31:0] index_pos;
		logic pos_primary;
		logic pos_strobe;
		logic irq;
	} feedback_state_type;
endpackage : encoder_feedback_pkg
`default_nettype wire

// [core/input_sync.sv]
// Three-stage synchroniser for the encoder pins
`timescale 1ns/100ps
`default_nettype none
module input_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] pins_in,
	output logic [2:0] pins_out
);
	encoder_feedback_pkg::sync_state_type s_q;
	encoder_feedback_pkg::sync_state_type s_d;

	always_comb begin
		s_d = s_q;
		s_d.s1 = pins_in;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		// A change counts once the two later stages agree
		for (int i = 0; i < 3; i++) begin
			if (s_q.s2[i] == s_q.s3[i]) begin
				s_d.val[i] = s_q.s3[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pins_out = s_q.val;
endmodule : input_sync
`default_nettype wire

// [core/quadrature_counter.sv]
// Four-times quadrature decoder with index marker
`timescale 1ns/100ps
`default_nettype none
module quadrature_counter (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire encoder_feedback_pkg::quad_pins_type pins,
	output logic [31:0] count,
	output logic index_pulse,
	output logic step_error
);
	encoder_feedback_pkg::quad_state_type s_q;
	encoder_feedback_pkg::quad_state_type s_d;

	always_comb begin
		s_d = s_q;
		s_d.index_pulse = 1'b0;
		s_d.step_error = 1'b0;
		s_d.prev_ab = {pins.a, pins.b};
		s_d.prev_x = pins.x;
		if (enable) begin
			case ({pins.a ^ s_q.prev_ab[1], pins.b ^ s_q.prev_ab[0]})
				2'b10, 2'b01: begin
					// Up when A leads, down when B leads
					if (s_q.prev_ab[1] == pins.b) begin
						s_d.count = s_q.count + 32'h0000_0001; // [RQ1] [RQ12]
					end else begin
						s_d.count = s_q.count - 32'h0000_0001; // [RQ1] [RQ12]
					end
				end
				2'b11: begin
					s_d.step_error = 1'b1;
				end
				default: begin
				end
			endcase
			s_d.index_pulse = pins.x & ~s_q.prev_x; // [RQ2]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign count = s_q.count;
	assign index_pulse = s_q.index_pulse;
	assign step_error = s_q.step_error;
endmodule : quadrature_counter
`default_nettype wire

// [verification/encoder_feedback_chk.sv]
// Port assertions for the encoder feedback block
`include "encoder_feedback_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module encoder_feedback_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic index_or_serial_clock_out,
	input wire logic index_or_serial_clock_oe_n,
	input wire logic [31:0] position_out,
	input wire logic position_strobe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [11:0] high_cnt_q, high_cnt_d;
	always_comb begin
		high_cnt_d = high_cnt_q;
		if (!index_or_serial_clock_out) begin
			high_cnt_d = 12'h000;
		end else if (high_cnt_q != 12'hfff) begin
			high_cnt_d = high_cnt_q + 12'h001;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_cnt_q <= 12'hfff;
		end else begin
			high_cnt_q <= high_cnt_d;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	sequence low_half;
		!index_or_serial_clock_out [*4];
	endsequence
	clk_idle_a: assert property (index_or_serial_clock_oe_n |-> index_or_serial_clock_out)
		else $error("serial clock toggles while released");
	low_phase_a: assert property ($fell(index_or_serial_clock_out) |->
		low_half ##1 index_or_serial_clock_out)
		else $error("serial clock low phase wrong length");
	recovery_gap_a: assert property ($fell(index_or_serial_clock_out) &&
		high_cnt_q > 12'h008 |-> high_cnt_q >= `RECOVERY_CYCLES)
		else $error("frame started before recovery ended");
	strobe_pulse_a: assert property (position_strobe |=> !position_strobe)
		else $error("position strobe longer than one cycle");
	quad_step_a: assert property (index_or_serial_clock_oe_n &&
		$past(index_or_serial_clock_oe_n) && position_out != $past(position_out) |->
		(position_out - $past(position_out)) inside {32'h0000_0001, 32'hffff_ffff})
		else $error("quadrature count jumped by more than one");
	write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped before taken");
endmodule : encoder_feedback_chk
bind encoder_feedback_interface encoder_feedback_chk u_encoder_feedback_chk (.aclk, .aresetn,
	.awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .rready, .rdata,
	.index_or_serial_clock_out, .index_or_serial_clock_oe_n, .position_out, .position_strobe);
`default_nettype wire

// [verification/ssi_encoder_model.sv]
// Absolute serial encoder answering clock bursts
`timescale 1ns/100ps
`default_nettype none
module ssi_encoder_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sclk,
	input wire logic [24:0] word,
	output logic sdata
);
	logic sclk_q, busy;
	logic [4:0] left;
	logic [24:0] sh;
	logic [7:0] idle;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sclk_q <= 1'b1;
			busy <= 1'b0;
			left <= 5'h00;
			sh <= '0;
			idle <= 8'h00;
			sdata <= 1'b1;
		end else begin
			sclk_q <= sclk;
			idle <= sclk ? (idle == 8'hff ? idle : idle + 8'h01) : 8'h00;
			if (sclk_q && !sclk && !busy) begin // first fall latches the word
				busy <= 1'b1;
				sh <= word;
				left <= 5'h19;
			end else if (!sclk_q && sclk && busy) begin // shift MSB first on rises
				sdata <= (left != 5'h00) ? sh[24] : 1'b0;
				sh <= {sh[23:0], 1'b0};
				left <= (left != 5'h00) ? left - 5'h01 : left;
			end else if (busy && idle > 8'h14) begin // Line back to its idle level
				busy <= 1'b0;
				sdata <= 1'b1;
			end
		end
	end
endmodule : ssi_encoder_model
`default_nettype wire

// [verification/encoder_feedback_interface_bench.sv]
// Register-level tests of the encoder feedback block
`include "encoder_feedback_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module encoder_feedback_interface_bench;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, position_out;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, qi = 2'h0;
	logic awready, wready, bvalid, arready, rvalid, clk_out, clk_oe_n, strobe, primary, irq, sdata;
	logic quad_a = 1'b0, quad_b = 1'b0, idx = 1'b0, ser_on = 1'b0;
	logic [24:0] word = 25'h1234567;
	int mismatches = 0, checks = 0;
	wire logic pin_a = ser_on ? sdata : quad_a;
	wire logic pin_x = clk_oe_n ? idx : clk_out;
	always #5 aclk = ~aclk;
	encoder_feedback_interface u_encoder_feedback_interface (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .phase_a_or_serial_data_in(pin_a),
		.phase_b_in(quad_b), .index_or_serial_clock_in(pin_x), .index_or_serial_clock_out(clk_out),
		.index_or_serial_clock_oe_n(clk_oe_n), .position_out, .position_strobe(strobe),
		.position_primary(primary), .irq);
	ssi_encoder_model u_ssi_encoder_model (.aclk, .aresetn, .sclk(pin_x), .word, .sdata);
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
		awaddr <= {24'h0, addr};
		wdata <= data;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		check("bresp", {30'h0, resp}, {30'h0, bresp});
	endtask : axi_write
	task automatic axi_read(input logic [7:0] addr, input logic [31:0] exp, input logic [1:0] resp);
		araddr <= {24'h0, addr};
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0;
		check("rdata", exp, rdata);
		check("rresp", {30'h0, resp}, {30'h0, rresp});
	endtask : axi_read
	task automatic quad_move(input int steps, input logic up);
		repeat (steps) begin
			qi = up ? qi + 2'h1 : qi - 2'h1;
			quad_a <= qi[0] ^ qi[1];
			quad_b <= qi[1];
			// Three sync stages, decoder and output register settle within eight
			repeat (8) @(posedge aclk);
		end
	endtask : quad_move
	task automatic wait_strobe;
		do @(posedge aclk); while (strobe !== 1'b1);
	endtask : wait_strobe
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge aclk);
		mismatches++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		check("clk idle", 32'h1, {31'h0, clk_out});
		check("primary", 32'h1, {31'h0, primary});
		axi_read(`REG_CTRL, `CTRL_RESET, `RESP_OKAY);
		axi_read(`REG_CFG, `CFG_RESET, `RESP_OKAY);
		axi_read(`REG_CPR, `CPR_RESET, `RESP_OKAY);
		axi_read(8'h40, 32'h0, `RESP_SLVERR);
		axi_write(8'h40, 32'h5, `RESP_SLVERR);
		quad_move(8, 1'b1);
		check("count up", 32'h8, position_out);
		quad_move(3, 1'b0);
		check("count down", 32'h5, position_out);
		axi_write(`REG_MASK, 32'h20, `RESP_OKAY);
		idx <= 1'b1;
		repeat (8) @(posedge aclk);
		idx <= 1'b0;
		axi_read(`REG_STATUS, 32'h20, `RESP_OKAY);
		axi_read(`REG_INDEX_POS, 32'h5, `RESP_OKAY);
		check("irq set", 32'h1, {31'h0, irq});
		axi_write(`REG_STATUS, 32'h20, `RESP_OKAY);
		repeat (3) @(posedge aclk);
		check("irq clear", 32'h0, {31'h0, irq});
		axi_write(`REG_CTRL, 32'h08, `RESP_OKAY);
		check("secondary", 32'h0, {31'h0, primary});
		axi_write(`REG_CPR, 32'h1000, `RESP_OKAY);
		axi_write(`REG_CFG, 32'h0319, `RESP_OKAY);
		axi_write(`REG_MASK, 32'h01, `RESP_OKAY);
		ser_on <= 1'b1;
		axi_write(`REG_CTRL, 32'h01, `RESP_OKAY);
		// Mode first; encoder model needs a quiet line before the burst
		repeat (32) @(posedge aclk);
		check("clock driven", 32'h0, {31'h0, clk_oe_n});
		axi_write(`REG_CTRL, 32'h11, `RESP_OKAY);
		wait_strobe();
		check("ssi position", 32'h567, position_out);
		axi_read(`REG_TURNS, 32'h1234, `RESP_OKAY);
		axi_read(`REG_RAW_LO, 32'h1234567, `RESP_OKAY);
		check("done irq", 32'h1, {31'h0, irq});
		axi_write(`REG_STATUS, 32'h01, `RESP_OKAY);
		word <= 25'h1fff001;
		axi_write(`REG_CTRL, 32'h05, `RESP_OKAY);
		repeat (2) begin
			wait_strobe();
			check("run position", 32'h001, position_out);
		end
		complete_run();
	end
endmodule : encoder_feedback_interface_bench
`default_nettype wire
